/* adapter_error_code_reporter_tb.sv */
`timescale 1ns/1ns
module adapter_error_code_reporter_tb;
    import aecr_pkg::*;
    logic clk_sys, rst_b, cmd_start, cmd_end, passthru;
    logic start_list, stop_list, list_attn, go;
    logic [12:0] pb_count, sb_count, pl_idx, sl_idx;
    logic [15:0] sel_timeout_us, resel_timeout_us;
    logic xfer_active, xfer_sb_list, sys_bus_err, scsi_op_active;
    logic sel_active, disc_wait, scsi_parity_err, info_phase;
    logic list_active, sb_write, cmd_reject, status_port_valid;
    logic [7:0] sb_offset, status_port;
    logic [3:0] sb_byte_en;
    logic [31:0] sb_data;
    logic [2:0] kind;
    int mismatches, cmp_count, cycles;

    // short counts keep every timeout scene to a few dozen cycles
    aecr_error_reporter #(.XFER_CYC(20), .SCSI_CYC(50), .TICK(2), .TW(24))
    i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .cmd_start(cmd_start),
        .cmd_end(cmd_end), .passthru(passthru), .start_list(start_list),
        .stop_list(stop_list), .list_attn(list_attn), .pb_count(pb_count),
        .sb_count(sb_count), .param_list_in_index(pl_idx),
        .status_list_out_index(sl_idx), .xfer_active(xfer_active),
        .xfer_sb_list(xfer_sb_list), .sys_bus_err(sys_bus_err),
        .scsi_op_active(scsi_op_active), .sel_active(sel_active),
        .disc_wait(disc_wait), .scsi_parity_err(scsi_parity_err),
        .info_phase(info_phase), .sel_timeout_us(sel_timeout_us),
        .resel_timeout_us(resel_timeout_us), .list_active(list_active),
        .sb_write(sb_write), .sb_offset(sb_offset), .sb_byte_en(sb_byte_en),
        .sb_data(sb_data), .cmd_reject(cmd_reject),
        .status_port(status_port), .status_port_valid(status_port_valid));

    aecr_far_model i_far (.go(go), .kind(kind), .xfer_active(xfer_active),
        .xfer_sb_list(xfer_sb_list), .sys_bus_err(sys_bus_err),
        .scsi_op_active(scsi_op_active), .sel_active(sel_active),
        .disc_wait(disc_wait), .scsi_parity_err(scsi_parity_err),
        .info_phase(info_phase));

    task automatic print_verdict;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
            input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check_val

    task automatic check_bit(input logic got, input logic exp,
            input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask : check_bit

    task automatic pulse(ref logic s);
        @(negedge clk_sys) s = 1'b1;
        @(negedge clk_sys) s = 1'b0;
    endtask : pulse

    // waits a bounded time for the error byte write and returns its code
    task automatic wait_write(output logic [7:0] code, output logic rej);
        for (int n = 0; n < 20 && sb_write !== 1'b1; n++) @(negedge clk_sys);
        check_bit(sb_write, 1'b1, "write");
        check_val(sb_offset, 32'h4, "offset");
        check_val(sb_byte_en, 32'h4, "lanes");
        check_val(sb_data & 32'hFF00FFFF, 32'h0, "other bytes");
        code = sb_data[23:16];
        rej = cmd_reject;
    endtask : wait_write

    task automatic list_cmd(input int which, input logic [7:0] exp);
        logic [7:0] code;
        logic rej;
        if (which == 0) pulse(start_list);
        else if (which == 1) pulse(stop_list);
        else pulse(list_attn);
        if (exp !== ERR_NONE) begin
            wait_write(code, rej);
            check_val(code, exp, "list code");
            check_bit(rej, 1'b1, "reject");
        end
        repeat (3) @(negedge clk_sys);
    endtask : list_cmd

    task automatic run_cmd(input logic pt, input logic [2:0] k,
            input int cyc, input logic [7:0] exp);
        logic [7:0] code;
        logic rej;
        passthru = pt;
        pulse(cmd_start);
        kind = k;
        go = 1'b1;
        repeat (cyc) @(negedge clk_sys);
        go = 1'b0;
        repeat (4) @(negedge clk_sys);
        pulse(cmd_end);
        wait_write(code, rej);
        check_val(code, exp, "status code");
        repeat (3) @(negedge clk_sys);
    endtask : run_cmd

    task automatic test_size;
        sb_count = 13'h0002;
        pb_count = 13'h0001;
        list_cmd(0, ERR_LIST_SIZE);
        pb_count = 13'h07F3;
        list_cmd(0, ERR_LIST_SIZE);
        pb_count = 13'h0002;
        sb_count = 13'h0001;
        list_cmd(0, ERR_LIST_SIZE);
        sb_count = 13'h1001;
        list_cmd(0, ERR_LIST_SIZE);
        check_bit(status_port_valid, 1'b0, "port idle");
        pb_count = 13'h07F2;
        sb_count = 13'h1000;
        list_cmd(0, ERR_NONE);
        check_bit(list_active, 1'b1, "active");
        list_cmd(1, ERR_NONE);
        check_bit(list_active, 1'b0, "stopped");
        $display("test_size done");
    endtask : test_size

    task automatic test_state;
        list_cmd(1, ERR_LIST_STATE);
        check_val(status_port, ERR_LIST_STATE, "port");
        check_bit(status_port_valid, 1'b1, "port valid");
        list_cmd(2, ERR_LIST_STATE);
        pb_count = 13'h0002;
        sb_count = 13'h0002;
        list_cmd(0, ERR_NONE);
        list_cmd(0, ERR_LIST_STATE);
        check_bit(list_active, 1'b1, "still active");
        $display("test_state done");
    endtask : test_state

    task automatic test_index;
        pl_idx = 13'h0003;
        run_cmd(1'b0, 3'h0, 2, ERR_LIST_INDEX);
        pl_idx = 13'h0002;
        run_cmd(1'b0, 3'h0, 2, ERR_NONE);
        sl_idx = 13'h0003;
        run_cmd(1'b0, 3'h0, 2, ERR_LIST_INDEX);
        sl_idx = 13'h0000;
        check_val(status_port, ERR_LIST_INDEX, "port");
        list_cmd(1, ERR_NONE);
        $display("test_index done");
    endtask : test_index

    task automatic test_bus;
        run_cmd(1'b0, 3'h1, 10, ERR_LIST_INDEX);
        run_cmd(1'b0, 3'h2, 30, ERR_BUS_ERROR);
        check_val(status_port, ERR_BUS_ERROR, "port");
        run_cmd(1'b0, 3'h3, 30, ERR_FW_TIMEOUT);
        check_val(status_port, ERR_FW_TIMEOUT, "port");
        $display("test_bus done");
    endtask : test_bus

    task automatic test_scsi;
        sel_timeout_us = 16'h0003;
        resel_timeout_us = 16'h0003;
        run_cmd(1'b1, 3'h4, 20, ERR_SEL_TIMEOUT);
        run_cmd(1'b1, 3'h5, 20, ERR_DISC_TIMEOUT);
        run_cmd(1'b1, 3'h6, 70, ERR_SCSI_TIMEOUT);
        run_cmd(1'b1, 3'h7, 5, ERR_PARITY);
        run_cmd(1'b0, 3'h7, 5, ERR_NONE);
        sel_timeout_us = 16'h0064;
        run_cmd(1'b1, 3'h4, 20, ERR_NONE);
        check_val(status_port, ERR_FW_TIMEOUT, "port kept");
        $display("test_scsi done");
    endtask : test_scsi

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // a hang anywhere ends the run well past the expected length
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        {rst_b, cmd_start, cmd_end, passthru, go} = 5'h0;
        {start_list, stop_list, list_attn} = 3'h0;
        {pb_count, sb_count, pl_idx, sl_idx} = 52'h0;
        kind = 3'h0;
        sel_timeout_us = 16'h0000;
        resel_timeout_us = 16'h0000;
        repeat (16) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (2) @(negedge clk_sys);
        check_val(sb_offset, 32'h4, "reset offset");
        test_size();
        test_state();
        test_index();
        test_bus();
        test_scsi();
        print_verdict();
    end
endmodule : adapter_error_code_reporter_tb

/* aecr_error_reporter.sv */
`timescale 1ns/1ns
// Functional notes
// - start-list with parameter block count outside 2..2034 reports 0Fh.
// - start-list with status block count outside 2..4096 reports 0Fh.
// - parameter input index beyond list capacity reports 10h.
// - status output index beyond list capacity reports 10h.
// - bus error while touching the status list reports 10h.
// - start-list while a list is active reports 11h.
// - stop-list while no list is active reports 11h.
// - list channel attention with no active list reports 11h.
// - system bus transfers are timed; overrun reports 14h.
// - system bus error moving parameters or data reports 15h.
// - pass-through SCSI operation overrunning its time reports 1Dh.
// - pass-through selection unanswered within timeout reports 1Eh.
// - pass-through disconnected target not reselecting within timeout reports 1Fh.
// - pass-through parity error in any information phase reports 20h.
// - code goes to error byte, lane two of status word at 04h.
// - codes 10h, 11h, 14h, 15h also appear on the status port.
module aecr_error_reporter
    import aecr_pkg::*;
#(
    parameter int XFER_CYC = XFER_TIMEOUT_CYC,
    parameter int SCSI_CYC = SCSI_OP_TIMEOUT_CYC,
    parameter int TICK = TICK_CYC,
    parameter int TW = 24
) (
    input wire logic clk_sys,          // 100 MHz system clock
    input wire logic rst_b,            // async reset, active low
    input wire logic cmd_start,        // pulse: a command begins
    input wire logic cmd_end,          // pulse: command completes
    input wire logic passthru,         // level: command is pass-through
    input wire logic start_list,       // pulse: start-list command
    input wire logic stop_list,        // pulse: stop-list command
    input wire logic list_attn,        // pulse: list channel attention
    input wire logic [12:0] pb_count,  // parameter block count field
    input wire logic [12:0] sb_count,  // status block count field
    input wire logic [12:0] param_list_in_index,  // host input index
    input wire logic [12:0] status_list_out_index, // status output index
    input wire logic xfer_active,      // level: system bus transfer busy
    input wire logic xfer_sb_list,     // level: transfer hits status list
    input wire logic sys_bus_err,      // async: bus error from bus
    input wire logic scsi_op_active,   // level: scsi operation running
    input wire logic sel_active,       // level: selection in progress
    input wire logic disc_wait,        // level: awaiting reselection
    input wire logic scsi_parity_err,  // async: scsi parity error pin
    input wire logic info_phase,       // level: scsi information phase
    input wire logic [15:0] sel_timeout_us,   // selection timeout, us
    input wire logic [15:0] resel_timeout_us, // reselection timeout, us
    output logic list_active,          // level: command list active
    output logic sb_write,             // pulse: write status error byte
    output logic [7:0] sb_offset,      // status block word offset
    output logic [3:0] sb_byte_en,     // byte enable for error lane
    output logic [31:0] sb_data,       // status word, code in lane 2
    output logic cmd_reject,           // pulse: command terminated
    output logic [7:0] status_port,    // catastrophic code mirror
    output logic status_port_valid     // level: status port holds code
);
    // bus error and parity arrive from pins, so they pass two stages
    logic bus_err_s;
    logic parity_s;

    aecr_sync #(.W(2)) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .d({sys_bus_err, scsi_parity_err}),
        .q({bus_err_s, parity_s})
    );

    // microsecond tick for host-programmed scsi timeouts
    logic [15:0] tick_cnt;
    wire tick_hit = (tick_cnt == 16'(TICK - 1));
    wire [15:0] next_tick_cnt = tick_hit ? 16'h0000 : tick_cnt + 16'h0001;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= next_tick_cnt;
        end
    end

    logic xfer_to;
    logic scsi_to;
    logic sel_to;
    logic disc_to;

    aecr_timer #(.W(TW)) u_xfer_tmr (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .run(xfer_active),
        .step(1'b1),
        .limit(TW'(XFER_CYC)),
        .expired(xfer_to)
    );

    aecr_timer #(.W(TW)) u_scsi_tmr (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .run(scsi_op_active && passthru),
        .step(1'b1),
        .limit(TW'(SCSI_CYC)),
        .expired(scsi_to)
    );

    // timeouts follow whatever the host last configured
    aecr_timer #(.W(TW)) u_sel_tmr (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .run(sel_active && passthru),
        .step(tick_hit),
        .limit(TW'(sel_timeout_us)),
        .expired(sel_to)
    );

    aecr_timer #(.W(TW)) u_disc_tmr (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .run(disc_wait && passthru),
        .step(tick_hit),
        .limit(TW'(resel_timeout_us)),
        .expired(disc_to)
    );

    // list bookkeeping
    logic [12:0] pb_cap;
    logic [12:0] sb_cap;

    wire pb_bad = (pb_count < PB_COUNT_MIN) || (pb_count > PB_COUNT_MAX);
    wire sb_bad = (sb_count < SB_COUNT_MIN) || (sb_count > SB_COUNT_MAX);
    wire size_bad = start_list && !list_active && (pb_bad || sb_bad);
    wire start_state_bad = start_list && list_active;
    wire stop_state_bad = stop_list && !list_active;
    wire attn_state_bad = list_attn && !list_active;
    wire state_bad = start_state_bad || stop_state_bad || attn_state_bad;
    wire start_ok = start_list && !list_active && !pb_bad && !sb_bad;
    wire stop_ok = stop_list && list_active;

    wire pb_idx_bad = list_active && (param_list_in_index > pb_cap);
    wire sb_idx_bad = list_active && (status_list_out_index > sb_cap);
    wire sb_bus_bad = bus_err_s && xfer_active && xfer_sb_list;
    wire idx_bad = pb_idx_bad || sb_idx_bad || sb_bus_bad;
    wire bus_bad = bus_err_s && xfer_active && !xfer_sb_list;
    wire par_bad = parity_s && passthru && info_phase;

    // timer flags clear a cycle after their run input falls; gating them
    // keeps a finished phase from raising a late timeout code
    wire xfer_over = xfer_to && xfer_active;
    wire sel_over = sel_to && sel_active && passthru;
    wire disc_over = disc_to && disc_wait && passthru;
    wire scsi_over = scsi_to && scsi_op_active && passthru;

    // priority among faults seen in the same cycle
    wire [7:0] fault_code =
        size_bad ? ERR_LIST_SIZE :
        state_bad ? ERR_LIST_STATE :
        idx_bad ? ERR_LIST_INDEX :
        bus_bad ? ERR_BUS_ERROR :
        xfer_over ? ERR_FW_TIMEOUT :
        sel_over ? ERR_SEL_TIMEOUT :
        disc_over ? ERR_DISC_TIMEOUT :
        scsi_over ? ERR_SCSI_TIMEOUT :
        par_bad ? ERR_PARITY : ERR_NONE;
    wire fault = (fault_code != ERR_NONE);

    wire catastrophic = (fault_code == ERR_LIST_INDEX) ||
        (fault_code == ERR_LIST_STATE) ||
        (fault_code == ERR_FW_TIMEOUT) ||
        (fault_code == ERR_BUS_ERROR);

    // per-command latch of the first fault
    aecr_cmd_e cmd_st;
    aecr_cmd_e next_cmd_st;
    logic [7:0] held_code;
    wire first_fault = fault && (held_code == ERR_NONE);
    wire cmd_immediate = start_list || stop_list || list_attn;
    wire [7:0] report_code = first_fault ? fault_code : held_code;
    wire do_write = (cmd_end && cmd_st == AECR_ST_BUSY) ||
        (cmd_immediate && state_bad) || size_bad;

    always_comb begin
        next_cmd_st = cmd_st;
        case (cmd_st)
            AECR_ST_IDLE: begin
                if (cmd_start) begin
                    next_cmd_st = AECR_ST_BUSY;
                end
            end
            AECR_ST_BUSY: begin
                if (cmd_end) begin
                    next_cmd_st = AECR_ST_DONE;
                end
            end
            AECR_ST_DONE: begin
                next_cmd_st = cmd_start ? AECR_ST_BUSY : AECR_ST_IDLE;
            end
            default: begin
                next_cmd_st = AECR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmd_st <= AECR_ST_IDLE;
        end else begin
            cmd_st <= next_cmd_st;
        end
    end

    // a new command clears the record, but a fault in that cycle still lands
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            held_code <= ERR_NONE;
        end else if (cmd_start) begin
            held_code <= fault ? fault_code : ERR_NONE;
        end else if (do_write) begin
            held_code <= ERR_NONE;
        end else if (first_fault && cmd_st == AECR_ST_BUSY) begin
            held_code <= fault_code;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            list_active <= 1'b0;
            pb_cap <= 13'h0000;
            sb_cap <= 13'h0000;
        end else if (start_ok) begin
            list_active <= 1'b1;
            pb_cap <= pb_count;
            sb_cap <= sb_count;
        end else if (stop_ok) begin
            list_active <= 1'b0;
        end
    end

    // status block write: code sits in byte lane 2 of the word at 04h
    wire [7:0] wr_code = (size_bad || state_bad) ? fault_code : report_code;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sb_write <= 1'b0;
            sb_offset <= 8'h00;
            sb_byte_en <= 4'h0;
            sb_data <= 32'h00000000;
            cmd_reject <= 1'b0;
        end else begin
            sb_write <= do_write;
            sb_offset <= SB_ERR_WORD_OFFSET;
            sb_byte_en <= 4'h1 << SB_ERR_BYTE_LANE;
            sb_data <= {8'h00, wr_code, 16'h0000};
            cmd_reject <= size_bad || state_bad;
        end
    end

    // status port keeps the last catastrophic code until reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            status_port <= ERR_NONE;
            status_port_valid <= 1'b0;
        end else if (fault && catastrophic) begin
            status_port <= fault_code;
            status_port_valid <= 1'b1;
        end
    end

    a_size_reject: assert property (@(posedge clk_sys) disable iff (!rst_b)
        size_bad |=> sb_write && sb_data[23:16] == 8'h0F && cmd_reject)
        else $error("bad list size not reported");
    a_sb_count_max: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (start_list && !list_active && sb_count == 13'h1001)
        |=> sb_data[23:16] == 8'h0F)
        else $error("status count 4097 accepted");
    a_start_active: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (start_list && list_active) |=> sb_data[23:16] == 8'h11
        && list_active)
        else $error("start on active list not rejected");
    a_stop_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (stop_list && !list_active && !start_list)
        |=> cmd_reject && status_port == 8'h11)
        else $error("stop with no list not rejected");
    a_attn_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (list_attn && !list_active && !start_list && !stop_list)
        |=> status_port == 8'h11)
        else $error("attention with no list not flagged");
    a_index_catas: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (pb_idx_bad && !size_bad && !state_bad)
        |=> status_port == 8'h10 && status_port_valid)
        else $error("bad index not mirrored");
    a_xfer_tmo: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (fault_code == ERR_FW_TIMEOUT) |-> xfer_active
        && $past(xfer_active, 8))
        else $error("transfer timeout without running transfer");
    a_parity_rep: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (fault_code == 8'h20) |-> $past(scsi_parity_err, 2)
        && passthru)
        else $error("parity code without parity error");
    a_port_steady: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!(fault && catastrophic)) |=> $stable(status_port))
        else $error("status port changed without catastrophic fault");

endmodule : aecr_error_reporter

/* aecr_far_model.sv */
`timescale 1ns/1ns
module aecr_far_model (
    input wire logic go,              // level: a fault scene is playing
    input wire logic [2:0] kind,      // which scene is playing
    output logic xfer_active,         // system bus transfer busy
    output logic xfer_sb_list,        // transfer touches status list
    output logic sys_bus_err,         // bus error from the bus
    output logic scsi_op_active,      // scsi operation running
    output logic sel_active,          // selection in progress
    output logic disc_wait,           // waiting for reselection
    output logic scsi_parity_err,     // parity fault on the scsi bus
    output logic info_phase           // scsi information phase
);
    // every line rests low between scenes, as idle bus and phase lines do
    wire scene_on = go;
    assign xfer_active = scene_on && (kind inside {3'h1, 3'h2, 3'h3});
    assign xfer_sb_list = scene_on && kind == 3'h1;
    assign sys_bus_err = scene_on && (kind == 3'h1 || kind == 3'h2);
    assign sel_active = scene_on && kind == 3'h4;
    assign disc_wait = scene_on && kind == 3'h5;
    assign scsi_op_active = scene_on && kind == 3'h6;
    // parity is only ever flagged inside an information phase
    assign info_phase = scene_on && kind == 3'h7;
    assign scsi_parity_err = scene_on && kind == 3'h7;
endmodule : aecr_far_model

/* aecr_pkg.sv */
package aecr_pkg;

    // error codes placed in the status block error byte
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_LIST_SIZE = 8'h0F;
    localparam logic [7:0] ERR_LIST_INDEX = 8'h10;
    localparam logic [7:0] ERR_LIST_STATE = 8'h11;
    localparam logic [7:0] ERR_FW_TIMEOUT = 8'h14;
    localparam logic [7:0] ERR_BUS_ERROR = 8'h15;
    localparam logic [7:0] ERR_SCSI_TIMEOUT = 8'h1D;
    localparam logic [7:0] ERR_SEL_TIMEOUT = 8'h1E;
    localparam logic [7:0] ERR_DISC_TIMEOUT = 8'h1F;
    localparam logic [7:0] ERR_PARITY = 8'h20;

    // list sizing limits
    localparam logic [12:0] PB_COUNT_MIN = 13'h0002;
    localparam logic [12:0] PB_COUNT_MAX = 13'h07F2;
    localparam logic [12:0] SB_COUNT_MIN = 13'h0002;
    localparam logic [12:0] SB_COUNT_MAX = 13'h1000;

    // status block error byte location
    localparam logic [7:0] SB_ERR_WORD_OFFSET = 8'h04;
    localparam int SB_ERR_BYTE_LANE = 2;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int XFER_TIMEOUT_US = 100;
    localparam int XFER_TIMEOUT_CYC = XFER_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int SCSI_OP_TIMEOUT_MS = 10;
    localparam int SCSI_OP_TIMEOUT_CYC =
        SCSI_OP_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TICK_US = 1;
    localparam int TICK_CYC = TICK_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        AECR_ST_IDLE = 3'b001,
        AECR_ST_BUSY = 3'b010,
        AECR_ST_DONE = 3'b100
    } aecr_cmd_e;

endpackage : aecr_pkg

/* aecr_sync.sv */
`timescale 1ns/1ns
module aecr_sync
    import aecr_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk_sys,     // system clock
    input wire logic rst_b,       // async reset, active low
    input wire logic [W-1:0] d,   // asynchronous inputs
    output logic [W-1:0] q        // synchronised outputs
);
    logic [W-1:0] meta;

    // meta feeds only the second stage
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : aecr_sync

/* aecr_timer.sv */
`timescale 1ns/1ns
module aecr_timer
    import aecr_pkg::*;
#(
    parameter int W = 24
) (
    input wire logic clk_sys,     // system clock
    input wire logic rst_b,       // async reset, active low
    input wire logic run,         // count while high, clear while low
    input wire logic step,        // advance by one when high
    input wire logic [W-1:0] limit, // expiry count
    output logic expired          // level, high once count reaches limit
);
    logic [W-1:0] count;
    wire at_limit = (count >= limit) && (limit != '0);
    wire [W-1:0] next_count = at_limit ? count : count + W'(1);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
            expired <= 1'b0;
        end else if (!run) begin
            count <= '0;
            expired <= 1'b0;
        end else begin
            if (step) begin
                count <= next_count;
            end
            expired <= at_limit;
        end
    end
endmodule : aecr_timer
